// ==== logic/cfe_evaluator.sv ====
// Overview of operation
// - contactor coil copies its rung result into the relay at once.
// - inverted contactor makes the relay the inverse of its rung result.
// - falling-edge coil sets relay for exactly one scan on a 1 to 0 change.
// - rising-edge coil sets relay for exactly one scan on a 0 to 1 change.
// - impulse coil toggles the relay on each 0 to 1 change of its result.
// - set coil latches the relay on until a reset coil clears it.
// - set and reset in one scan: the later coil decides.
// - several coils of one relay in a scan: the last one wins.
// - power loss or stop clears every non-retentive relay, latched ones too.
// - retentive relays keep a stored 1 across power loss and stop.
// - power loss or stop clears non-retentive function relay actual values.
// - function relay coils take effect only after the whole pass.
// - edge coils only for marker groups and jumps, never for outputs.
// - expansion relays drive outputs only when an expansion unit is present.
// - a function relay coil is evaluated at most once per scan.
// - a function relay starts from its own coil and drives its contact.
// - rungs and coils are evaluated only in run mode.
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module cfe_evaluator #(
   parameter int NUM_RELAYS = cfe_pkg::NUM_RELAYS,
   parameter int FR_NUM = cfe_pkg::FR_NUM
) (
   // clock and reset
   input wire logic core_clk_i,
   input wire logic rst_i,
   // operating state
   input wire logic run_i,
   input wire logic power_ok_i,
   input wire logic expansion_present_i,
   input wire logic [NUM_RELAYS-1:0] retain_mask_i,
   input wire logic [FR_NUM-1:0] fr_retain_i,
   // scan framing
   input wire logic scan_start_i,
   input wire logic scan_end_i,
   // relay coil stream
   input wire logic coil_valid_i,
   input wire logic [2:0] coil_fn_i,
   input wire logic [cfe_pkg::IDX_W-1:0] coil_idx_i,
   input wire logic coil_result_i,
   // function relay coil stream
   input wire logic fr_valid_i,
   input wire logic [cfe_pkg::FR_IDX_W-1:0] fr_idx_i,
   input wire logic fr_result_i,
   // relay states
   output logic [NUM_RELAYS-1:0] relay_state_o,
   output logic [cfe_pkg::Q_NUM-1:0] q_out_o,
   output logic [cfe_pkg::S_NUM-1:0] s_out_o,
   // function relays
   output logic [FR_NUM-1:0] fr_coil_o,
   output logic [FR_NUM-1:0] fr_clear_o,
   // errors
   output logic illegal_coil_o,
   output logic dup_coil_o
);
   // parameter values the index map cannot serve
   if (NUM_RELAYS != cfe_pkg::NUM_RELAYS || FR_NUM < 1 || FR_NUM > cfe_pkg::FR_NUM) begin : g_bad_params
      $error("cfe_evaluator: unsupported parameter values");
   end

   typedef enum logic {PH_IDLE, PH_SCAN} cfe_phase_t;

   ////////////////////////////////////////////////////////////////////////////
   // edge functions only on marker and jump relays
   function automatic logic edge_ok(input logic [cfe_pkg::IDX_W-1:0] idx);
      int i;
      i = int'(idx);
      edge_ok = (i >= cfe_pkg::M_BASE && i < cfe_pkg::M_BASE + cfe_pkg::M_NUM) ||
                (i >= cfe_pkg::N_BASE && i < cfe_pkg::N_BASE + cfe_pkg::N_NUM) ||
                (i >= cfe_pkg::J_BASE && i < cfe_pkg::J_BASE + cfe_pkg::J_NUM);
   endfunction : edge_ok

   function automatic logic is_edge_fn(input logic [2:0] fn);
      is_edge_fn = (fn == cfe_pkg::FN_FALL) || (fn == cfe_pkg::FN_RISE);
   endfunction : is_edge_fn

   ////////////////////////////////////////////////////////////////////////////
   cfe_phase_t phase_reg;
   cfe_phase_t phase_next;
   logic [NUM_RELAYS-1:0] state_reg;
   logic [NUM_RELAYS-1:0] state_next;
   logic [NUM_RELAYS-1:0] prev_reg;
   logic [NUM_RELAYS-1:0] prev_next;
   logic [FR_NUM-1:0] fr_work_reg;
   logic [FR_NUM-1:0] fr_work_next;
   logic [FR_NUM-1:0] fr_seen_reg;
   logic [FR_NUM-1:0] fr_seen_next;
   logic [FR_NUM-1:0] fr_coil_reg;
   logic [FR_NUM-1:0] fr_coil_next;
   logic [FR_NUM-1:0] fr_clear_reg;
   logic [FR_NUM-1:0] fr_clear_next;
   logic [cfe_pkg::Q_NUM-1:0] q_reg;
   logic [cfe_pkg::Q_NUM-1:0] q_next;
   logic [cfe_pkg::S_NUM-1:0] s_reg;
   logic [cfe_pkg::S_NUM-1:0] s_next;
   logic illegal_reg;
   logic illegal_next;
   logic dup_reg;
   logic dup_next;
   logic live;
   logic coil_legal;
   logic coil_take;
   logic fr_take;
   logic cur_bit;
   logic prev_bit;
   logic alu_bit;

   assign live = run_i && power_ok_i && (phase_reg == PH_SCAN);
   assign coil_legal = (int'(coil_idx_i) < NUM_RELAYS) &&
                       (!is_edge_fn(coil_fn_i) || edge_ok(coil_idx_i)) &&
                       (coil_fn_i <= cfe_pkg::FN_RESET);
   assign coil_take = live && coil_valid_i && coil_legal;
   assign fr_take = live && fr_valid_i && (int'(fr_idx_i) < FR_NUM);
   assign cur_bit = coil_take ? state_reg[coil_idx_i] : 1'b0;
   assign prev_bit = coil_take ? prev_reg[coil_idx_i] : 1'b0;

   cfe_coil_alu u_alu (
      .fn_i(coil_fn_i),
      .result_i(coil_result_i),
      .prev_i(prev_bit),
      .cur_i(cur_bit),
      .nxt_o(alu_bit)
   );

   ////////////////////////////////////////////////////////////////////////////
   // scan evaluation
   always_comb begin
      phase_next = phase_reg;
      state_next = state_reg;
      prev_next = prev_reg;
      fr_work_next = fr_work_reg;
      fr_seen_next = fr_seen_reg;
      fr_coil_next = fr_coil_reg;
      fr_clear_next = '0;
      illegal_next = 1'b0;
      dup_next = 1'b0;
      if (!run_i || !power_ok_i) begin
         state_next = state_reg & retain_mask_i;
         prev_next = '0;
         fr_work_next = fr_work_reg & fr_retain_i;
         fr_coil_next = fr_coil_reg & fr_retain_i;
         fr_clear_next = ~fr_retain_i;
         fr_seen_next = '0;
         phase_next = PH_IDLE;
      end else begin
         unique case (phase_reg)
            PH_IDLE: begin
               if (scan_start_i) begin
                  phase_next = PH_SCAN;
                  fr_seen_next = '0;
               end
            end
            PH_SCAN: begin
               if (coil_valid_i && !coil_legal)
                  illegal_next = 1'b1;
               if (coil_take) begin
                  state_next[coil_idx_i] = alu_bit;
                  prev_next[coil_idx_i] = coil_result_i;
               end
               if (fr_take) begin
                  if (fr_seen_reg[fr_idx_i])
                     dup_next = 1'b1;
                  else begin
                     fr_work_next[fr_idx_i] = fr_result_i;
                     fr_seen_next[fr_idx_i] = 1'b1;
                  end
               end
               if (scan_end_i) begin
                  fr_coil_next = fr_work_next;
                  phase_next = PH_IDLE;
               end
            end
         endcase
      end
      q_next = state_next[cfe_pkg::Q_BASE +: cfe_pkg::Q_NUM];
      s_next = expansion_present_i ? state_next[cfe_pkg::S_BASE +: cfe_pkg::S_NUM] : '0;
   end

   always_ff @(posedge core_clk_i) begin
      if (rst_i) begin
         phase_reg <= PH_IDLE;
         state_reg <= '0;
         prev_reg <= '0;
         fr_work_reg <= '0;
         fr_seen_reg <= '0;
         fr_coil_reg <= '0;
         fr_clear_reg <= '0;
         q_reg <= '0;
         s_reg <= '0;
         illegal_reg <= 1'b0;
         dup_reg <= 1'b0;
      end else begin
         phase_reg <= phase_next;
         state_reg <= state_next;
         prev_reg <= prev_next;
         fr_work_reg <= fr_work_next;
         fr_seen_reg <= fr_seen_next;
         fr_coil_reg <= fr_coil_next;
         fr_clear_reg <= fr_clear_next;
         q_reg <= q_next;
         s_reg <= s_next;
         illegal_reg <= illegal_next;
         dup_reg <= dup_next;
      end
   end

   assign relay_state_o = state_reg;
   assign q_out_o = q_reg;
   assign s_out_o = s_reg;
   assign fr_coil_o = fr_coil_reg;
   assign fr_clear_o = fr_clear_reg;
   assign illegal_coil_o = illegal_reg;
   assign dup_coil_o = dup_reg;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   contact_follow_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
      coil_take && coil_fn_i == cfe_pkg::FN_CONTACT
      |=> relay_state_o[$past(coil_idx_i)] == $past(coil_result_i))
      else $error("contactor relay did not follow its result");

   invert_follow_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
      coil_take && coil_fn_i == cfe_pkg::FN_INVERT
      |=> relay_state_o[$past(coil_idx_i)] != $past(coil_result_i))
      else $error("inverted contactor not inverse of result");

   fall_pulse_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
      coil_take && coil_fn_i == cfe_pkg::FN_FALL
      |=> relay_state_o[$past(coil_idx_i)] == ($past(prev_reg[coil_idx_i]) && !$past(coil_result_i)))
      else $error("falling edge pulse wrong");

   rise_pulse_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
      coil_take && coil_fn_i == cfe_pkg::FN_RISE
      |=> relay_state_o[$past(coil_idx_i)] == (!$past(prev_reg[coil_idx_i]) && $past(coil_result_i)))
      else $error("rising edge pulse wrong");

   toggle_flip_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
      coil_take && coil_fn_i == cfe_pkg::FN_TOGGLE && coil_result_i && !prev_reg[coil_idx_i]
      |=> relay_state_o[$past(coil_idx_i)] != $past(state_reg[coil_idx_i]))
      else $error("impulse relay did not toggle");

   latch_set_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
      coil_take && coil_result_i && (coil_fn_i == cfe_pkg::FN_SET || coil_fn_i == cfe_pkg::FN_RESET)
      |=> relay_state_o[$past(coil_idx_i)] == ($past(coil_fn_i) == cfe_pkg::FN_SET))
      else $error("set or reset coil not applied");

   stop_clear_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !run_i || !power_ok_i
      |=> relay_state_o == ($past(relay_state_o) & $past(retain_mask_i)))
      else $error("stop did not clear non-retentive relays");

   fr_clear_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !power_ok_i |=> fr_clear_o == ~$past(fr_retain_i) && (fr_coil_o & ~$past(fr_retain_i)) == '0)
      else $error("function relay values not cleared");

   fr_hold_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
      run_i && power_ok_i && !scan_end_i |=> $stable(fr_coil_o))
      else $error("function relay coil changed mid pass");

   edge_refuse_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
      live && coil_valid_i && is_edge_fn(coil_fn_i) && !edge_ok(coil_idx_i)
      |=> illegal_coil_o && $stable(relay_state_o))
      else $error("edge coil on output relay accepted");

   exp_off_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !expansion_present_i |=> s_out_o == '0)
      else $error("expansion outputs driven without unit");

   dup_flag_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
      fr_take && fr_seen_reg[fr_idx_i] |=> dup_coil_o && $stable(fr_work_reg))
      else $error("duplicate function relay coil not refused");

   idle_ignore_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
      run_i && power_ok_i && phase_reg == PH_IDLE |=> $stable(relay_state_o))
      else $error("relay changed outside a scan");

   prev_track_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
      coil_take |=> prev_reg[$past(coil_idx_i)] == $past(coil_result_i))
      else $error("previous rung result not kept");

   fr_apply_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
      live && scan_end_i && !fr_take |=> fr_coil_o == $past(fr_work_reg))
      else $error("function relay coils not applied at pass end");

   stop_fr_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !run_i |=> (fr_clear_o == ~$past(fr_retain_i)) && ((fr_coil_o & ~$past(fr_retain_i)) == '0))
      else $error("stop did not clear function relay values");

   stop_quiet_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
      !run_i |=> !illegal_coil_o && !dup_coil_o)
      else $error("coil evaluated while stopped");

   exp_follow_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
      expansion_present_i |=> s_out_o == relay_state_o[cfe_pkg::S_BASE +: cfe_pkg::S_NUM])
      else $error("expansion outputs do not follow their relays");

   q_follow_a: assert property (@(posedge core_clk_i) disable iff (rst_i)
      q_out_o == relay_state_o[cfe_pkg::Q_BASE +: cfe_pkg::Q_NUM])
      else $error("output terminals do not follow their relays");
endmodule : cfe_evaluator
`default_nettype wire

// ==== logic/cfe_pkg.sv ====
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
package cfe_pkg;
   // relay address map, one flat index per relay
   localparam int NUM_RELAYS = 72;
   localparam int IDX_W = 7;
   localparam int Q_BASE = 0;
   localparam int Q_NUM = 8;
   localparam int M_BASE = 8;
   localparam int M_NUM = 16;
   localparam int N_BASE = 24;
   localparam int N_NUM = 16;
   localparam int S_BASE = 40;
   localparam int S_NUM = 8;
   localparam int D_BASE = 48;
   localparam int D_NUM = 16;
   localparam int J_BASE = 64;
   localparam int J_NUM = 8;
   // function relay coils
   localparam int FR_NUM = 16;
   localparam int FR_IDX_W = 4;
   // coil function codes
   localparam logic [2:0] FN_CONTACT = 3'h0;
   localparam logic [2:0] FN_INVERT = 3'h1;
   localparam logic [2:0] FN_FALL = 3'h2;
   localparam logic [2:0] FN_RISE = 3'h3;
   localparam logic [2:0] FN_TOGGLE = 3'h4;
   localparam logic [2:0] FN_SET = 3'h5;
   localparam logic [2:0] FN_RESET = 3'h6;
endpackage : cfe_pkg
`default_nettype wire

// ==== logic/cfe_coil_alu.sv ====
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// next relay state from one coil evaluation
module cfe_coil_alu (
   // coil
   input wire logic [2:0] fn_i,
   input wire logic result_i,
   input wire logic prev_i,
   input wire logic cur_i,
   // relay
   output logic nxt_o
);
   always_comb begin
      unique case (fn_i)
         cfe_pkg::FN_CONTACT: nxt_o = result_i;
         cfe_pkg::FN_INVERT: nxt_o = ~result_i;
         cfe_pkg::FN_FALL: nxt_o = prev_i & ~result_i;
         cfe_pkg::FN_RISE: nxt_o = ~prev_i & result_i;
         cfe_pkg::FN_TOGGLE: nxt_o = cur_i ^ (~prev_i & result_i);
         cfe_pkg::FN_SET: nxt_o = cur_i | result_i;
         cfe_pkg::FN_RESET: nxt_o = cur_i & ~result_i;
         default: nxt_o = cur_i;
      endcase
   end
endmodule : cfe_coil_alu
`default_nettype wire

// ==== bench/cfe_rung_model.sv ====
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
// rung side: frames each pass and streams coil results
module cfe_rung_model (
   // clock
   input wire logic core_clk_i,
   // scan framing
   output logic scan_start_o,
   output logic scan_end_o,
   // relay coils
   output logic coil_valid_o,
   output logic [2:0] coil_fn_o,
   output logic [cfe_pkg::IDX_W-1:0] coil_idx_o,
   output logic coil_result_o,
   // function relay coils
   output logic fr_valid_o,
   output logic [cfe_pkg::FR_IDX_W-1:0] fr_idx_o,
   output logic fr_result_o
);
   initial begin
      {scan_start_o, scan_end_o, coil_valid_o, fr_valid_o} = 4'h0;
      {coil_fn_o, coil_idx_o, coil_result_o} = 11'h0;
      {fr_idx_o, fr_result_o} = 5'h0;
   end
   // open a pass
   task automatic start();
      @(posedge core_clk_i);
      scan_start_o <= 1'b1;
   endtask : start
   // one coil per cycle, relay coil or function relay coil
   task automatic coil(input logic fr, input logic [2:0] fn, input logic [6:0] idx, input logic res);
      @(posedge core_clk_i);
      scan_start_o <= 1'b0;
      coil_valid_o <= !fr;
      fr_valid_o <= fr;
      coil_fn_o <= fn;
      coil_idx_o <= idx;
      fr_idx_o <= idx[3:0];
      coil_result_o <= res;
      fr_result_o <= res;
   endtask : coil
   // close the pass; coil index and result lines flip so stale values never look valid
   task automatic finish();
      @(posedge core_clk_i);
      {scan_start_o, coil_valid_o, fr_valid_o} <= 3'h0;
      scan_end_o <= 1'b1;
      coil_idx_o <= ~coil_idx_o;
      coil_result_o <= ~coil_result_o;
      fr_result_o <= ~fr_result_o;
      @(posedge core_clk_i);
      scan_end_o <= 1'b0;
   endtask : finish
endmodule : cfe_rung_model
`default_nettype wire

// ==== bench/tb_top.sv ====
`timescale 1ns/1ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module tb_top;
   logic core_clk_i = 1'b0;
   logic rst_i = 1'b1;
   logic run_i = 1'b1;
   logic power_ok_i = 1'b1;
   logic expansion_present_i = 1'b0;
   logic [71:0] retain_mask_i = 72'h1000;
   logic [15:0] fr_retain_i = 16'h0001;
   logic ss, se, cv, cr, fv, fres, ill, dup;
   logic [2:0] cf;
   logic [6:0] ci;
   logic [3:0] fi;
   logic [71:0] st;
   logic [7:0] q_out, s_out;
   logic [15:0] fr_coil, fr_clear;
   int mismatches = 0;
   int checked = 0;
   always #5 core_clk_i = ~core_clk_i;
   cfe_rung_model cfe_rung_model_i (.core_clk_i(core_clk_i), .scan_start_o(ss), .scan_end_o(se),
      .coil_valid_o(cv), .coil_fn_o(cf), .coil_idx_o(ci), .coil_result_o(cr),
      .fr_valid_o(fv), .fr_idx_o(fi), .fr_result_o(fres));
   cfe_evaluator cfe_evaluator_i (.core_clk_i(core_clk_i), .rst_i(rst_i), .run_i(run_i),
      .power_ok_i(power_ok_i), .expansion_present_i(expansion_present_i), .retain_mask_i(retain_mask_i),
      .fr_retain_i(fr_retain_i), .scan_start_i(ss), .scan_end_i(se), .coil_valid_i(cv), .coil_fn_i(cf),
      .coil_idx_i(ci), .coil_result_i(cr), .fr_valid_i(fv), .fr_idx_i(fi), .fr_result_i(fres),
      .relay_state_o(st), .q_out_o(q_out), .s_out_o(s_out), .fr_coil_o(fr_coil), .fr_clear_o(fr_clear),
      .illegal_coil_o(ill), .dup_coil_o(dup));
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [71:0] seen, input logic [71:0] exp);
      checked++;
      if (seen !== exp) begin
         mismatches++;
         $display("CHECK FAILED at %0t: got %h want %h", $time, seen, exp);
      end
   endtask : chk
   task automatic end_of_test();
      if (mismatches == 0 && checked > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : end_of_test
   // one pass of two relay coils, outputs settled on return
   task automatic pass(input logic [2:0] f1, input logic [6:0] i1, input logic r1,
                       input logic [2:0] f2, input logic [6:0] i2, input logic r2);
      cfe_rung_model_i.start();
      cfe_rung_model_i.coil(1'b0, f1, i1, r1);
      cfe_rung_model_i.coil(1'b0, f2, i2, r2);
      cfe_rung_model_i.finish();
      #1;
   endtask : pass
   ////////////////////////////////////////////////////////////////////////////
   task automatic t_contact();
      pass(cfe_pkg::FN_CONTACT, 7'h08, 1'b1, cfe_pkg::FN_INVERT, 7'h09, 1'b1);
      chk(st[8], 1'b1);
      chk(st[9], 1'b0);
      pass(cfe_pkg::FN_CONTACT, 7'h00, 1'b1, cfe_pkg::FN_INVERT, 7'h09, 1'b0);
      chk(q_out, 8'h01);
      chk(st[9], 1'b1);
   endtask : t_contact
   task automatic t_edges();
      logic [4:0] res = 5'b10110;
      logic [4:0] rise = 5'b10010;
      logic [4:0] fall = 5'b01000;
      logic [4:0] tog = 5'b01110;
      for (int k = 0; k < 5; k++) begin
         pass(cfe_pkg::FN_RISE, 7'h0a, res[k], cfe_pkg::FN_FALL, 7'h18, res[k]);
         pass(cfe_pkg::FN_TOGGLE, 7'h0b, res[k], cfe_pkg::FN_FALL, 7'h40, res[k]);
         chk(st[10], rise[k]);
         chk(st[24], fall[k]);
         chk(st[64], fall[k]);
         chk(st[11], tog[k]);
      end
   endtask : t_edges
   task automatic t_latch();
      pass(cfe_pkg::FN_SET, 7'h0c, 1'b1, cfe_pkg::FN_RESET, 7'h0c, 1'b0);
      chk(st[12], 1'b1);
      pass(cfe_pkg::FN_SET, 7'h0c, 1'b0, cfe_pkg::FN_RESET, 7'h0c, 1'b0);
      chk(st[12], 1'b1);
      pass(cfe_pkg::FN_SET, 7'h0c, 1'b1, cfe_pkg::FN_RESET, 7'h0c, 1'b1);
      chk(st[12], 1'b0);
      pass(cfe_pkg::FN_RESET, 7'h0c, 1'b1, cfe_pkg::FN_SET, 7'h0c, 1'b1);
      chk(st[12], 1'b1);
      pass(cfe_pkg::FN_CONTACT, 7'h0d, 1'b1, cfe_pkg::FN_CONTACT, 7'h0d, 1'b0);
      chk(st[13], 1'b0);
      pass(cfe_pkg::FN_INVERT, 7'h0d, 1'b1, cfe_pkg::FN_CONTACT, 7'h0d, 1'b1);
      chk(st[13], 1'b1);
   endtask : t_latch
   task automatic t_illegal(input logic [2:0] fn, input logic [6:0] idx);
      cfe_rung_model_i.start();
      cfe_rung_model_i.coil(1'b0, fn, idx, 1'b1);
      @(posedge core_clk_i);
      #1;
      chk(ill, 1'b1);
      cfe_rung_model_i.finish();
      #1;
      chk(ill, 1'b0);
      chk(st, 72'h0000_0000_0000_0037_01);
   endtask : t_illegal
   task automatic t_expansion();
      pass(cfe_pkg::FN_CONTACT, 7'h28, 1'b1, cfe_pkg::FN_CONTACT, 7'h28, 1'b1);
      chk(st[40], 1'b1);
      chk(s_out, 8'h00);
      @(posedge core_clk_i);
      expansion_present_i <= 1'b1;
      @(posedge core_clk_i);
      #1;
      chk(s_out, 8'h01);
   endtask : t_expansion
   task automatic t_function();
      cfe_rung_model_i.start();
      cfe_rung_model_i.coil(1'b1, 3'h0, 7'h02, 1'b1);
      cfe_rung_model_i.coil(1'b1, 3'h0, 7'h02, 1'b0);
      @(posedge core_clk_i);
      #1;
      chk(dup, 1'b1);
      chk(fr_coil, 16'h0000);
      cfe_rung_model_i.coil(1'b1, 3'h0, 7'h00, 1'b1);
      cfe_rung_model_i.finish();
      #1;
      chk(fr_coil, 16'h0005);
   endtask : t_function
   task automatic t_stop();
      pass(cfe_pkg::FN_SET, 7'h0e, 1'b1, cfe_pkg::FN_CONTACT, 7'h08, 1'b1);
      @(posedge core_clk_i);
      run_i <= 1'b0;
      @(posedge core_clk_i);
      #1;
      chk(st, 72'h1000);
      chk(fr_coil, 16'h0001);
      chk(fr_clear, 16'hfffe);
      pass(cfe_pkg::FN_CONTACT, 7'h08, 1'b1, cfe_pkg::FN_SET, 7'h0e, 1'b1);
      chk(st, 72'h1000);
      @(posedge core_clk_i);
      run_i <= 1'b1;
      power_ok_i <= 1'b0;
      @(posedge core_clk_i);
      #1;
      chk(st, 72'h1000);
      chk(fr_clear, 16'hfffe);
      @(posedge core_clk_i);
      power_ok_i <= 1'b1;
      @(posedge core_clk_i);
      #1;
      chk(fr_clear, 16'h0000);
      chk(st, 72'h1000);
   endtask : t_stop
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (2000) @(posedge core_clk_i);
      mismatches++;
      end_of_test();
   end
   initial begin
      repeat (2) @(posedge core_clk_i);
      rst_i <= 1'b0;
      #1;
      chk(st, 72'h0);
      t_contact();
      t_edges();
      t_latch();
      t_illegal(cfe_pkg::FN_RISE, 7'h01);
      t_illegal(cfe_pkg::FN_FALL, 7'h29);
      t_illegal(3'h7, 7'h0f);
      t_illegal(cfe_pkg::FN_CONTACT, 7'h48);
      t_expansion();
      t_function();
      t_stop();
      end_of_test();
   end
endmodule : tb_top
`default_nettype wire
